// file: shared/sbs_pkg.sv
// Shared constants for the servo burst sampler and its processor end.
package sbs_pkg;
	localparam int CLK_NS        = 8;
	// Servo window and strobe times, in ns, as documented.
	localparam int WINDOW_NS     = 600000;
	localparam int A_START_NS    = 300000;
	localparam int A_LEN_NS      = 75000;
	localparam int B_OFFSET_NS   = 112500;
	// Index one-shots.
	localparam int SETTLE_NS     = 20000;
	localparam int INDEX_NS      = 10000;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int INDEX_CYC     = (INDEX_NS + CLK_NS - 1) / CLK_NS;
	// Slot clock from the processor: 15 ticks make one 37.5 us unit.
	localparam int TICK_NS       = 2500;
	localparam int TICK_CYC      = TICK_NS / CLK_NS;
	localparam int DIV_FIRST     = 5;
	localparam int DIV_SECOND    = 3;
	localparam int DIV_DECADE    = 10;
	localparam int UNIT_NS       = TICK_NS * DIV_FIRST * DIV_SECOND;
	// Decade stage decode: tap bit high at counts 8 and 9.
	localparam int DEC_TAP_BIT   = 3;
	localparam logic [3:0] DEC_B_COUNT = 4'h1;
	// Converter clock and least wait before reading a result.
	localparam int CONV_TICK_NS  = 80;
	localparam int CONV_TICK_CYC = CONV_TICK_NS / CLK_NS;
	localparam int CONV_WAIT     = 256;
	localparam int DATA_W        = 8;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [2:0] HEAD_ZERO = 3'h0;
	// Processor sequencing states.
	typedef enum logic [2:0] {
		SBS_IDLE  = 3'b000,
		SBS_START = 3'b001,
		SBS_WAIT  = 3'b010,
		SBS_READ  = 3'b011,
		SBS_NEXT  = 3'b100,
		SBS_DONE  = 3'b101
	} sbs_state_t;
endpackage : sbs_pkg

// file: shared/sbs_if.sv
// Link between the servo burst sampler and the drive processor.
`timescale 1ns/100ps
interface sbs_if;
	logic       slot_tick;
	logic       conv_tick;
	logic       conv_sel_b;
	logic       comp_en;
	logic       conv_start;
	logic [7:0] ramp_val;
	logic       conv_match;
	logic       index_irq_n;
	logic [2:0] head_req;

	modport dev (
		input  slot_tick, conv_tick, conv_sel_b, comp_en, conv_start,
		input  head_req,
		output ramp_val, conv_match, index_irq_n
	);
	modport proc (
		output slot_tick, conv_tick, conv_sel_b, comp_en, conv_start,
		output head_req,
		input  ramp_val, conv_match, index_irq_n
	);
endinterface : sbs_if

// file: hw/sbs_one_shot.sv
// Retriggerable one-shot with a fixed length in clock cycles.
`timescale 1ns/100ps
module sbs_one_shot
#(
	parameter int CYCLES = 2
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic trig,
	output logic      active,
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_reg;

	// Refused at elaboration: a zero length would never start a pulse.
	if (CYCLES < 1)
	begin : g_bad_cycles
		$error("one-shot length must be at least one cycle");
	end

	// A trigger loads the full length; the pulse ends when it runs out.
	always_ff @(posedge clk)
	begin
		if (rst)
			count_reg <= '0;
		else if (trig)
			count_reg <= CW'(CYCLES);
		else if (count_reg != '0)
			count_reg <= count_reg - 1'b1;
	end

	assign active = (count_reg != '0);
	assign done   = (count_reg == CW'(1)) && !trig;
endmodule : sbs_one_shot

// file: hw/sbs_device.sv
// Servo burst timing, index shaping, sample capture and ramp converter.
`timescale 1ns/100ps

// Overview of operation
// - all gating and sampling inside 600 us
// - host index only after both bursts
// - slot counter from raw index, gate then strobes
// - raw index clears flag, resets counters
// - after index, divide by five then three
// - decade stage: tap gives A, ten gives B
// - A strobe at 300 us for 75 us
// - B strobe 112.5 us after A
// - B end sets flag, starts 20 us delay
// - delay end gives 10 us host index
// - inverted index pulse interrupts the processor
// - flag set disables and discharges peak detector
// - each strobe loads its own hold channel
// - processor converts A, then B
// - start clears ramp counter driving 8-bit DAC
// - ramp counts while below sample, then holds
// - frozen count read through the read mux
// - processor compares A and B amplitudes
// - head forced to surface zero from raw index until B end
module sbs_device
	import sbs_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	sbs_if.dev                link,
	input  wire logic         raw_index,
	input  wire logic [W-1:0] read_level,
	output logic              host_index,
	output logic              index_level,
	output logic              peak_en,
	output logic              strobe_a,
	output logic              strobe_b,
	output logic [2:0]        head_sel,
	output logic [W-1:0]      peak_hold,
	output logic [W-1:0]      hold_a,
	output logic [W-1:0]      hold_b
);
	logic [2:0]   div5_reg;
	logic [1:0]   div3_reg;
	logic [3:0]   dec_reg;
	logic         ten_reg;
	logic         flag_reg;
	logic         strobe_b_dly_reg;
	logic [W-1:0] ramp_reg;
	logic [W-1:0] rd_reg;
	logic         match_reg;
	logic         div5_wrap;
	logic         div3_wrap;
	logic         dec_wrap;
	logic         b_end;
	logic         settle_done;
	logic         index_pulse;
	logic [W-1:0] sel_hold;

	// The timing chain must still fit the servo window at these rates.
	if (W != DATA_W)
	begin : g_bad_width
		$error("converter width must be eight bits");
	end
	if (UNIT_NS * 12 > WINDOW_NS)
	begin : g_bad_window
		$error("slot timing overruns the servo window");
	end

	assign div5_wrap = link.slot_tick && (div5_reg == 3'(DIV_FIRST - 1));
	assign div3_wrap = div5_wrap && (div3_reg == 2'(DIV_SECOND - 1));
	assign dec_wrap  = div3_wrap && (dec_reg == 4'(DIV_DECADE - 1));

	// Raw index holds every stage in reset; they run once it ends.
	always_ff @(posedge clk)
	begin
		if (rst || raw_index || flag_reg)
		begin
			div5_reg <= 3'h0;
			div3_reg <= 2'h0;
			dec_reg  <= 4'h0;
			ten_reg  <= 1'b0;
		end
		else
		begin
			if (link.slot_tick)
				div5_reg <= div5_wrap ? 3'h0 : div5_reg + 3'h1;
			if (div5_wrap)
				div3_reg <= div3_reg == 2'(DIV_SECOND - 1) ? 2'h0
				            : div3_reg + 2'h1;
			if (div3_wrap)
				dec_reg <= dec_wrap ? 4'h0 : dec_reg + 4'h1;
			if (dec_wrap)
				ten_reg <= 1'b1;
		end
	end

	// A follows the decade tap; B is one unit after the ten output.
	// A runs 300..375 us and B 412.5..450 us, well inside the window.
	assign strobe_a = !flag_reg && !raw_index && !ten_reg
	                  && dec_reg[DEC_TAP_BIT];
	assign strobe_b = !flag_reg && !raw_index && ten_reg
	                  && (dec_reg == DEC_B_COUNT);

	// Falling edge of the B strobe, seen one cycle late.
	always_ff @(posedge clk)
	begin
		if (rst || raw_index)
			strobe_b_dly_reg <= 1'b0;
		else
			strobe_b_dly_reg <= strobe_b;
	end

	assign b_end = strobe_b_dly_reg && !strobe_b;

	// Index flag: cleared by raw index, set at the end of the B strobe.
	// Raw index wins so a new revolution always restarts cleanly.
	always_ff @(posedge clk)
	begin
		if (rst)
			flag_reg <= 1'b1;
		else if (raw_index)
			flag_reg <= 1'b0;
		else if (b_end)
			flag_reg <= 1'b1;
	end

	assign index_level = flag_reg;
	assign peak_en     = !flag_reg;

	// Surface zero is forced from raw index until the flag sets at B end so servo can be read.
	always_ff @(posedge clk)
	begin
		if (rst)
			head_sel <= HEAD_ZERO;
		else if (!flag_reg || raw_index)
			head_sel <= HEAD_ZERO;
		else
			head_sel <= link.head_req;
	end

	// Peak detector: discharged while the flag is set, tracks when gated.
	always_ff @(posedge clk)
	begin
		if (rst || flag_reg)
			peak_hold <= ZERO8;
		else if (read_level > peak_hold)
			peak_hold <= read_level;
	end

	// Sample-holds follow the peak during their strobe and keep it after.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hold_a <= ZERO8;
			hold_b <= ZERO8;
		end
		else
		begin
			if (strobe_a)
				hold_a <= peak_hold;
			if (strobe_b)
				hold_b <= peak_hold;
		end
	end

	// The 20 us settle delay lets the forced head select release.
	sbs_one_shot #(
		.CYCLES (SETTLE_CYC)
	) u_settle (
		.clk    (clk),
		.rst    (rst),
		.trig   (b_end),
		.active (),
		.done   (settle_done)
	);

	// The 10 us pulse that the host sees as index.
	sbs_one_shot #(
		.CYCLES (INDEX_CYC)
	) u_index (
		.clk    (clk),
		.rst    (rst),
		.trig   (settle_done),
		.active (index_pulse),
		.done   ()
	);

	// Registered so the host line and interrupt carry no glitches.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			host_index       <= 1'b0;
			link.index_irq_n <= 1'b1;
		end
		else
		begin
			host_index       <= index_pulse;
			link.index_irq_n <= !index_pulse;
		end
	end

	assign sel_hold = link.conv_sel_b ? hold_b : hold_a;

	// Ramp converter: start clears, then the comparator gates the ticks.
	// The ramp never wraps since it stops on reaching the held level.
	always_ff @(posedge clk)
	begin
		if (rst)
			ramp_reg <= ZERO8;
		else if (link.conv_start)
			ramp_reg <= ZERO8;
		else if (link.comp_en && link.conv_tick
		         && (ramp_reg < sel_hold))
			ramp_reg <= ramp_reg + 8'h01;
	end

	// Read multiplexer holds the frozen count for the processor.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_reg    <= ZERO8;
			match_reg <= 1'b0;
		end
		else
		begin
			rd_reg    <= ramp_reg;
			match_reg <= link.comp_en && !link.conv_start
			             && (ramp_reg >= sel_hold);
		end
	end

	assign link.ramp_val   = rd_reg;
	assign link.conv_match = match_reg;
endmodule : sbs_device

// file: hw/sbs_processor.sv
// Processor end: slot and converter clocks, conversion of A then B.
`timescale 1ns/100ps
module sbs_processor
	import sbs_pkg::*;
#(
	parameter int WAIT_TICKS = CONV_WAIT
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	sbs_if.proc               link,
	input  wire logic [2:0]   head_cmd,
	output logic [7:0]        servo_a,
	output logic [7:0]        servo_b,
	output logic signed [8:0] offset,
	output logic              move_out,
	output logic              result_valid
);
	localparam int SW = $clog2(TICK_CYC);
	localparam int CW = $clog2(CONV_TICK_CYC + 1);
	localparam int WW = $clog2(WAIT_TICKS + 1);

	sbs_state_t    state_reg;
	logic [SW-1:0] slot_div_reg;
	logic [CW-1:0] conv_div_reg;
	logic [WW-1:0] wait_reg;
	logic          irq_dly_reg;
	logic          sel_b_reg;

	// Refused at elaboration: a shorter wait could read a running ramp.
	if (WAIT_TICKS < CONV_WAIT)
	begin : g_bad_wait
		$error("wait shorter than a full-scale ramp");
	end

	// Slot and converter clocks as one-cycle enables.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			slot_div_reg <= '0;
			conv_div_reg <= '0;
		end
		else
		begin
			slot_div_reg <= (slot_div_reg == SW'(TICK_CYC - 1)) ? '0
			                : slot_div_reg + 1'b1;
			conv_div_reg <= (conv_div_reg == CW'(CONV_TICK_CYC - 1)) ? '0
			                : conv_div_reg + 1'b1;
		end
	end

	assign link.slot_tick = (slot_div_reg == '0);
	assign link.conv_tick = (conv_div_reg == '0);
	assign link.head_req  = head_cmd;

	// Interrupt is active low; act on its falling edge.
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_dly_reg <= 1'b1;
		else
			irq_dly_reg <= link.index_irq_n;
	end

	// Convert A, read it, then B, then compare the two.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg    <= SBS_IDLE;
			sel_b_reg    <= 1'b0;
			wait_reg     <= '0;
			servo_a      <= ZERO8;
			servo_b      <= ZERO8;
			offset       <= '0;
			move_out     <= 1'b0;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= 1'b0;
			case (state_reg)
				SBS_IDLE:
					if (irq_dly_reg && !link.index_irq_n)
					begin
						sel_b_reg <= 1'b0;
						state_reg <= SBS_START;
					end
				SBS_START:
				begin
					wait_reg  <= '0;
					state_reg <= SBS_WAIT;
				end
				SBS_WAIT:
				begin
					if (link.conv_tick)
						wait_reg <= wait_reg + 1'b1;
					if (wait_reg == WW'(WAIT_TICKS))
						state_reg <= SBS_READ;
				end
				SBS_READ:
				begin
					if (sel_b_reg)
						servo_b <= link.ramp_val;
					else
						servo_a <= link.ramp_val;
					state_reg <= sel_b_reg ? SBS_DONE : SBS_NEXT;
				end
				SBS_NEXT:
				begin
					sel_b_reg <= 1'b1;
					state_reg <= SBS_START;
				end
				SBS_DONE:
				begin
					offset       <= $signed({1'b0, servo_a})
					                - $signed({1'b0, servo_b});
					move_out     <= servo_a > servo_b;
					result_valid <= 1'b1;
					state_reg    <= SBS_IDLE;
				end
				default:
					state_reg <= SBS_IDLE;
			endcase
		end
	end

	assign link.conv_sel_b = sel_b_reg;
	assign link.comp_en    = (state_reg == SBS_START)
	                         || (state_reg == SBS_WAIT);
	assign link.conv_start = (state_reg == SBS_START);
endmodule : sbs_processor

// file: tb/sbs_checker_sva.sv
// Concurrent checks on the link between sampler and processor.
`timescale 1ns/100ps
module sbs_checker
	import sbs_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       slot_tick,
	input wire logic       conv_tick,
	input wire logic       conv_sel_b,
	input wire logic       comp_en,
	input wire logic       conv_start,
	input wire logic [7:0] ramp_val,
	input wire logic       conv_match,
	input wire logic       index_irq_n,
	input wire logic [2:0] head_req
);
	int   irq_len;
	int   gap;
	int   tick_gap;
	logic seen;

	// Long spans are counted here, as a repetition cannot unroll them.
	always_ff @(posedge clk)
	begin
		irq_len <= (rst || index_irq_n) ? 0 : irq_len + 1;
		seen    <= !rst && (seen || conv_start);
		gap     <= (rst || conv_start) ? 0 : gap + 1;
		tick_gap <= (rst || slot_tick) ? 0 : tick_gap + 1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence irq_edge_s; $fell(index_irq_n); endsequence
	sequence start_a_s; conv_start && comp_en && !conv_sel_b; endsequence

	irq_len_a : assert property (
		$rose(index_irq_n) |-> irq_len == INDEX_CYC)
		else $error("Interrupt low time wrong.");
	irq_start_a : assert property (
		irq_edge_s |-> ##[1:4] start_a_s)
		else $error("Conversion of A not started.");
	start_en_a : assert property (
		conv_start |-> comp_en)
		else $error("Start without comparator enable.");
	start_clr_a : assert property (
		conv_start |-> ##2 ramp_val == ZERO8)
		else $error("Start did not clear the ramp.");
	ramp_step_a : assert property (
		$changed(ramp_val) |-> ramp_val == ZERO8 ||
			ramp_val == $past(ramp_val) + 8'h01)
		else $error("Ramp moved by other than one.");
	ramp_tick_a : assert property (
		$changed(ramp_val) && ramp_val != ZERO8 |->
			$past(conv_tick, 2) && $past(comp_en, 2))
		else $error("Ramp moved without an enabled tick.");
	ramp_hold_a : assert property (
		conv_match && !conv_start && !$past(conv_start) &&
			!$past(conv_start, 2) |=> $stable(ramp_val))
		else $error("Ramp moved after a match.");
	sel_stable_a : assert property (
		comp_en && $past(comp_en) |-> $stable(conv_sel_b))
		else $error("Channel changed during conversion.");
	start_gap_a : assert property (
		conv_start && seen |-> gap >= (CONV_WAIT - 1) * CONV_TICK_CYC)
		else $error("Second conversion started too soon.");
	tick_len_a : assert property (
		slot_tick |=> !slot_tick)
		else $error("Slot tick longer than one cycle.");
	tick_gap_a : assert property (
		$rose(slot_tick) |-> tick_gap == TICK_CYC - 1)
		else $error("Slot tick spacing wrong.");
endmodule : sbs_checker

// file: tb/tb_servo_burst_sampler.sv
// Self-checking bench joining the sampler to its processor end.
`timescale 1ns/100ps
module tb_servo_burst_sampler import sbs_pkg::*;;
	logic              clk, rst, raw_index, move_out, result_valid;
	logic              host_index, index_level, peak_en, strobe_a, strobe_b;
	logic [2:0]        head_cmd, head_sel;
	logic [7:0]        read_level, peak_hold, hold_a, hold_b;
	logic [7:0]        servo_a, servo_b, va, vb, rnd;
	logic signed [8:0] offset;
	int                n_errors, n_compared, cyc, t_rel;
	int                ta0, ta1, tb0, tb1, tf, th0, th1;

	sbs_if link_i ();
	sbs_device sbs_device_i (.clk(clk), .rst(rst), .link(link_i.dev),
		.raw_index(raw_index), .read_level(read_level),
		.host_index(host_index), .index_level(index_level),
		.peak_en(peak_en), .strobe_a(strobe_a), .strobe_b(strobe_b),
		.head_sel(head_sel), .peak_hold(peak_hold), .hold_a(hold_a),
		.hold_b(hold_b));
	sbs_processor sbs_processor_i (.clk(clk), .rst(rst),
		.link(link_i.proc), .head_cmd(head_cmd), .servo_a(servo_a),
		.servo_b(servo_b), .offset(offset), .move_out(move_out),
		.result_valid(result_valid));
	sbs_checker sbs_checker_i (.clk(clk), .rst(rst),
		.slot_tick(link_i.slot_tick), .conv_tick(link_i.conv_tick),
		.conv_sel_b(link_i.conv_sel_b), .comp_en(link_i.comp_en),
		.conv_start(link_i.conv_start), .ramp_val(link_i.ramp_val),
		.conv_match(link_i.conv_match),
		.index_irq_n(link_i.index_irq_n), .head_req(link_i.head_req));

	// Galois shift register; a full 255-state cycle, never stuck at zero.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], 1'b0} ^ (s[7] ? 8'h1D : 8'h00);
	endfunction : lfsr

	// Slot ticks to clock cycles.
	function automatic int ticks(input int n);
		ticks = n * TICK_CYC;
	endfunction : ticks

	// The held peak only grows within one window.
	function automatic logic [7:0] peak(input logic [7:0] a, b);
		peak = (a > b) ? a : b;
	endfunction : peak

	task automatic chk_val(input string w, input logic [8:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask : chk_val

	task automatic chk_time(input string w, input int e, g, tol);
		n_compared++;
		if (g < e - tol || g > e + tol)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", w, e, g);
		end
	endtask : chk_time

	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Edge stamps; spacing is judged from these once the run is over.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if ($fell(raw_index)) t_rel <= cyc;
		if ($rose(strobe_a)) ta0 <= cyc;
		if ($fell(strobe_a)) ta1 <= cyc;
		if ($rose(strobe_b)) tb0 <= cyc;
		if ($fell(strobe_b)) tb1 <= cyc;
		if ($rose(index_level)) tf <= cyc;
		if ($rose(host_index)) th0 <= cyc;
		if ($fell(host_index)) th1 <= cyc;
	end

	// One revolution takes some 64k cycles; the guard leaves slack.
	initial
	begin
		repeat (90000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// An aborted window, then a full one with both conversions.
	initial
	begin
		rst = 1'b1;
		raw_index = 1'b0;
		read_level = 8'h00;
		head_cmd = 3'h0;
		rnd = lfsr(8'h0A);
		va = rnd;
		vb = 8'hFF;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk_val("peak after reset", 9'h000, 9'(peak_en));
		@(posedge clk);
		head_cmd <= rnd[2:0];
		read_level <= va;
		raw_index <= 1'b1;
		repeat (3) @(posedge clk);
		raw_index <= 1'b0;
		repeat (2000) @(negedge clk);
		chk_val("peak enable", 9'h001, 9'(peak_en));
		chk_val("head forced", 9'h000, 9'(head_sel));
		chk_val("early index", 9'h000, 9'(host_index));
		@(posedge clk);
		raw_index <= 1'b1;
		repeat (3) @(posedge clk);
		raw_index <= 1'b0;
		@(negedge clk);
		while (ta1 <= t_rel) @(negedge clk);
		@(posedge clk);
		read_level <= vb;
		while (th1 <= t_rel) @(negedge clk);
		while (result_valid !== 1'b1) @(negedge clk);
		chk_time("a start", ticks(120), ta0 - t_rel, TICK_CYC + 2);
		chk_time("a length", ticks(30), ta1 - ta0, 2);
		chk_time("b offset", ticks(45), tb0 - ta0, 2);
		chk_time("b length", ticks(15), tb1 - tb0, 2);
		chk_time("flag set", 1, tf - tb1, 1);
		chk_time("host delay", SETTLE_CYC + 1, th0 - tf, 2);
		chk_time("host length", INDEX_CYC, th1 - th0, 0);
		chk_val("in window", 9'h001,
			9'(tb1 - t_rel < WINDOW_NS / CLK_NS));
		chk_val("hold a", {1'b0, va}, {1'b0, hold_a});
		chk_val("hold b", {1'b0, peak(va, vb)}, {1'b0, hold_b});
		chk_val("servo a", {1'b0, va}, {1'b0, servo_a});
		chk_val("servo b", {1'b0, vb}, {1'b0, servo_b});
		chk_val("offset", {1'b0, va} - {1'b0, vb}, offset);
		chk_val("move", 9'(va > vb), 9'(move_out));
		chk_val("head", 9'(head_cmd), 9'(head_sel));
		chk_val("peak off", 9'h000, 9'(peak_en));
		chk_val("peak discharged", 9'h000, {1'b0, peak_hold});
		finish_test();
	end
endmodule : tb_servo_burst_sampler
